// ### tb/ssf_line_model.sv
// serial partner model: received characters and shift engine pulses
`timescale 1ns/1ns
module ssf_line_model
   import ssf_pkg::*;
#(
   parameter int GAP = 2
)(
   input wire logic clk,
   output ssf_rx_t rx,
   output logic tx_load,
   output logic tx_last_bit
);
   initial begin
      rx = '0;
      tx_load = 1'b0;
      tx_last_bit = 1'b0;
   end

   // one character; data lines turn over once it is gone
   task automatic recv(input logic [7:0] d, input logic p, input logic [1:0] s, input logic m);
      @(posedge clk);
      rx <= {1'b1, d, p, s, m};
      @(posedge clk);
      rx <= {1'b0, ~d, ~p, ~s, ~m};
      repeat (GAP) @(posedge clk);
   endtask : recv

   // last low: shift register load, last high: final bit sent
   task automatic shift(input logic last);
      @(posedge clk);
      {tx_last_bit, tx_load} <= {last, ~last};
      @(posedge clk);
      {tx_last_bit, tx_load} <= 2'b00;
      repeat (GAP) @(posedge clk);
   endtask : shift
endmodule : ssf_line_model

// ### tb/ssf_status_bench.sv
// testbench of the serial status flag block
`timescale 1ns/1ns
module ssf_status_bench
   import ssf_pkg::*;
;
   logic clk, sys_rst, standby, module_stop, tx_load, tx_last_bit;
   logic xfer_tx_write, xfer_rx_read, chain_disable_select, xfer_count_nonzero;
   logic tx_mpb, tx_en, rx_en, tx_halt, rx_halt, tx_empty_req, rx_full_req;
   logic [7:0] rd_data, tx_byte, mode, xfer_tx_data, v, d, e;
   logic [1:0] s;
   logic [31:0] rnd;
   ssf_bus_t bus;
   ssf_rx_t rx;
   int fail_count, comparisons, cycles;

   ssf_status dut (
      .clk(clk), .sys_rst(sys_rst), .standby(standby), .module_stop(module_stop),
      .bus(bus), .rd_data(rd_data), .tx_load(tx_load), .tx_last_bit(tx_last_bit), .rx(rx),
      .xfer_tx_write(xfer_tx_write), .xfer_tx_data(xfer_tx_data), .xfer_rx_read(xfer_rx_read),
      .chain_disable_select(chain_disable_select), .xfer_count_nonzero(xfer_count_nonzero),
      .tx_byte(tx_byte), .tx_mpb(tx_mpb), .tx_en(tx_en), .rx_en(rx_en), .mode(mode),
      .tx_halt(tx_halt), .rx_halt(rx_halt), .tx_empty_req(tx_empty_req), .rx_full_req(rx_full_req)
   );
   ssf_line_model #(.GAP(2)) line (.clk(clk), .rx(rx), .tx_load(tx_load), .tx_last_bit(tx_last_bit));

   // ------------------------------
   // helpers
   // ------------------------------
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs

   // expected status bits 6..1 after one character; md = {odd, parity on}
   function automatic logic [7:0] rx_exp(input logic [7:0] dd, input logic p, input logic [1:0] ss,
      input logic m, input logic [1:0] md);
      logic fe, pe;
      fe = ~ss[0];
      pe = md[0] & ((^dd ^ p) != md[1]);
      return {1'b0, ~(fe | pe), 1'b0, fe, pe, 1'b0, m, 1'b0};
   endfunction : rx_exp

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] dd);
      @(posedge clk);
      bus <= '{addr: a, wdata: dd, we: 1'b1, re: 1'b0};
      @(posedge clk);
      bus <= '0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] dd);
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus <= '0;
      #1 dd = rd_data;
   endtask : rd

   // status read followed at once by a status write
   task automatic rdwr(input logic [7:0] dd, output logic [7:0] dr);
      @(posedge clk);
      bus <= '{addr: 3'h0, wdata: 8'h00, we: 1'b0, re: 1'b1};
      @(posedge clk);
      bus <= '{addr: 3'h0, wdata: dd, we: 1'b1, re: 1'b0};
      #1 dr = rd_data;
      @(posedge clk);
      bus <= '0;
   endtask : rdwr

   task automatic st(input logic [7:0] mask, input logic [7:0] exp, input string what);
      logic [7:0] r;
      rd(3'h0, r);
      chk(r & mask, exp, what);
   endtask : st

   task automatic xfer(input logic [1:0] g, input logic [7:0] dd);
      @(posedge clk);
      {chain_disable_select, xfer_count_nonzero, xfer_tx_write, xfer_rx_read} <= {g, 2'b11};
      xfer_tx_data <= dd;
      @(posedge clk);
      {xfer_tx_write, xfer_rx_read} <= 2'b00;
      #1;
   endtask : xfer

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : finish_test

   // ------------------------------
   // clock, watchdog, sequence
   // ------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         $display("unexpected %0t timeout", $time);
         finish_test();
      end
   end

   initial begin
      {sys_rst, standby, module_stop, xfer_tx_write, xfer_rx_read} = 5'h10;
      {chain_disable_select, xfer_count_nonzero} = 2'b00;
      bus = '0;
      xfer_tx_data = 8'h00;
      fail_count = 0;
      comparisons = 0;
      cycles = 0;
      rnd = 32'h0000_0031;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      st(8'hff, 8'h84, "reset status");
      wr(3'h0, 8'h01);
      st(8'hff, 8'h85, "zero write without read");
      chk({7'h0, tx_mpb}, 8'h01, "tx multiproc bit");
      wr(3'h0, 8'h7b);
      st(8'hff, 8'h85, "read-only bits");
      rd(3'h5, v);
      chk(v, 8'h00, "unmapped");
      wr(3'h2, 8'h55);
      rd(3'h2, v);
      chk(v, 8'h00, "rx data read-only");
      // random characters, first two with a zero in one stop bit
      wr(3'h3, 8'h02);
      for (int i = 0; i < 12; i++) begin
         rnd = xs(rnd);
         d = rnd[15:8];
         s = (i < 2) ? 2'(i + 1) : rnd[18:17];
         wr(3'h4, {4'h0, rnd[3] | (i < 2), rnd[2:1], 1'b0});
         line.recv(d, rnd[16], s, rnd[19]);
         e = rx_exp(d, rnd[16], s, rnd[19], rnd[2:1]);
         st(8'h7a, e, "rx flags");
         chk({7'h0, rx_halt}, {7'h0, |e[4:3]}, "rx halt");
         rd(3'h2, v);
         chk(v, d, "rx byte");
         wr(3'h0, 8'h00);
         #1 chk({6'h0, rx_halt, rx_full_req}, 8'h00, "flags cleared");
      end
      wr(3'h4, 8'h00);
      line.recv(8'ha5, 1'b0, 2'b11, 1'b0);
      line.recv(8'h5a, 1'b0, 2'b11, 1'b0);
      st(8'h60, 8'h60, "overrun");
      rd(3'h2, v);
      chk(v, 8'ha5, "old byte kept");
      line.recv(8'h3c, 1'b0, 2'b11, 1'b0);
      rd(3'h2, v);
      chk(v, 8'ha5, "halted");
      wr(3'h3, 8'h00);
      line.recv(8'hc3, 1'b0, 2'b11, 1'b0);
      st(8'h60, 8'h60, "rx off keeps flags");
      rd(3'h2, v);
      chk(v, 8'ha5, "rx off keeps data");
      wr(3'h3, 8'h02);
      wr(3'h0, 8'hdf);
      st(8'h60, 8'h40, "overrun cleared alone");
      wr(3'h0, 8'h00);
      line.recv(8'h18, 1'b0, 2'b11, 1'b0);
      wr(3'h0, 8'h00);
      #1 chk({7'h0, rx_full_req}, 8'h01, "no read no clear");
      st(8'h40, 8'h40, "rx full");
      wr(3'h0, 8'hff);
      #1 chk({7'h0, rx_full_req}, 8'h01, "one write");
      rdwr(8'hbf, v);
      chk(v & 8'h40, 8'h40, "read before clear");
      #1 chk({7'h0, rx_full_req}, 8'h00, "zero write");
      // controller clears, gated combinations before and after the one open combination
      line.recv(8'h81, 1'b0, 2'b11, 1'b0);
      wr(3'h3, 8'h03);
      for (int i = 0; i < 4; i++) begin
         rnd = xs(rnd);
         xfer(2'(3 - i), rnd[7:0]);
         chk({6'h0, rx_full_req, tx_empty_req}, (i < 2) ? 8'h03 : 8'h00, "xfer");
         chk(tx_byte, rnd[7:0], "tx data");
      end
      st(8'h84, 8'h00, "tx end cleared");
      line.shift(1'b1);
      st(8'h84, 8'h00, "last bit, data pending");
      line.shift(1'b0);
      st(8'h84, 8'h80, "load");
      line.shift(1'b1);
      st(8'h84, 8'h84, "last bit, empty");
      line.shift(1'b0);
      wr(3'h0, 8'h7f);
      st(8'h84, 8'h84, "new set drops read record");
      wr(3'h0, 8'h7f);
      st(8'h84, 8'h00, "tx empty cleared");
      wr(3'h3, 8'h02);
      st(8'h84, 8'h84, "tx off");
      wr(3'h3, 8'h03);
      wr(3'h4, 8'h01);
      #1 chk(mode, 8'h01, "mode register");
      chk({6'h0, rx_en, tx_en}, 8'h03, "enables");
      line.recv(8'h11, 1'b0, 2'b11, 1'b0);
      line.recv(8'h22, 1'b0, 2'b11, 1'b0);
      #1 chk({6'h0, tx_halt, rx_halt}, 8'h03, "sync halt");
      wr(3'h0, 8'h00);
      #1 chk({6'h0, tx_halt, rx_halt}, 8'h03, "error flag not read");
      @(posedge clk) standby <= 1'b1;
      @(posedge clk) standby <= 1'b0;
      st(8'hff, 8'h84, "standby");
      chk({7'h0, tx_halt}, 8'h00, "halt released");
      wr(3'h0, 8'h01);
      @(posedge clk) module_stop <= 1'b1;
      @(posedge clk) module_stop <= 1'b0;
      st(8'hff, 8'h84, "module stop");
      finish_test();
   end
endmodule : ssf_status_bench

// ### verilog/ssf_pkg.sv
// package: offsets, field positions and reset values of the serial status flag block
package ssf_pkg;

   // ----------------------------------------------------------------
   // register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] SSF_OFS_STATUS = 3'h0;
   localparam logic [2:0] SSF_OFS_TX_DATA = 3'h1;
   localparam logic [2:0] SSF_OFS_RX_DATA = 3'h2;
   localparam logic [2:0] SSF_OFS_CONTROL = 3'h3;
   localparam logic [2:0] SSF_OFS_MODE = 3'h4;

   // ----------------------------------------------------------------
   // serial_status fields
   // ----------------------------------------------------------------
   localparam int SSF_BIT_TX_BUFFER_EMPTY = 7;
   localparam int SSF_BIT_RX_BUFFER_FULL = 6;
   localparam int SSF_BIT_OVERRUN_ERROR = 5;
   localparam int SSF_BIT_FER = 4;
   localparam int SSF_BIT_PER = 3;
   localparam int SSF_BIT_TX_END = 2;
   localparam int SSF_BIT_MPB = 1;
   localparam int SSF_BIT_TX_MULTIPROC_BIT = 0;
   // index of each clearable flag inside the 5-bit flag vector
   localparam int SSF_FL_TX_BUFFER_EMPTY = 4;
   localparam int SSF_FL_RX_BUFFER_FULL = 3;
   localparam int SSF_FL_OVERRUN_ERROR = 2;
   localparam int SSF_FL_FER = 1;
   localparam int SSF_FL_PER = 0;
   localparam logic [7:0] SSF_STATUS_RST = 8'h84;
   localparam logic [4:0] SSF_FL_RST = SSF_STATUS_RST[7:3];
   localparam logic SSF_TX_END_RST = SSF_STATUS_RST[2];

   // ----------------------------------------------------------------
   // control and mode fields
   // ----------------------------------------------------------------
   localparam int SSF_CTL_TXEN = 0;
   localparam int SSF_CTL_RXEN = 1;
   localparam int SSF_MODE_SYNC = 0;
   localparam int SSF_MODE_PAR_EN = 1;
   localparam int SSF_MODE_ODD = 2;
   localparam int SSF_MODE_TWO_STOP = 3;
   localparam logic [7:0] SSF_CTL_RST = 8'h00;
   localparam logic [7:0] SSF_MODE_RST = 8'h00;
   localparam logic [7:0] SSF_DATA_RST = 8'hff;

   // ----------------------------------------------------------------
   // carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } ssf_bus_t;

   typedef struct packed {
      logic done;
      logic [7:0] data;
      logic parity;
      logic [1:0] stop;
      logic rx_multiproc_bit;
   } ssf_rx_t;

endpackage : ssf_pkg

// ### verilog/ssf_rx_check.sv
// receive frame checker: framing and parity verdicts for one received character
`timescale 1ns/1ns
module ssf_rx_check
   import ssf_pkg::*;
(
   input wire ssf_rx_t rx,
   input wire logic sync_mode,
   input wire logic par_en,
   input wire logic par_odd,
   input wire logic two_stop,
   output logic fer_hit,
   output logic per_hit
);

   function automatic logic ssf_ones_odd(input logic [7:0] d, input logic p);
      ssf_ones_odd = ^{d, p};
   endfunction : ssf_ones_odd

   wire logic first_stop;
   wire logic sum_odd;

   // only the first stop bit counts, the second is never examined
   assign first_stop = rx.stop[0];
   assign fer_hit = !sync_mode && !first_stop;
   assign sum_odd = ssf_ones_odd(rx.data, rx.parity);
   assign per_hit = !sync_mode && par_en && (sum_odd != par_odd);

   wire logic unused_two_stop;
   assign unused_two_stop = two_stop;

endmodule : ssf_rx_check

// ### verilog/ssf_status.sv
// serial status flag block: status register, data registers and flag update logic
// Behaviour
// - status loads 84h on reset, standby, stop
// - five flags cleared by zero writes, tx_empty and rx_full also by controller
// - zero write clears only after flag read one
// - tx_end and rx multiproc bit are read-only
// - tx_empty set when tx off or loaded
// - controller tx data write clears tx_empty
// - controller rx data read clears rx_full
// - controller clears only without chain-disable, count nonzero
// - clean reception sets rx_full, copies byte
// - error halt or rx off keeps data, rx_full
// - reception while rx_full set raises overrun
// - overrun keeps old byte, drops new byte
// - error flags halt rx; sync also tx
// - clearing rx enable keeps error flags
// - async zero stop bit sets framing error
// - only first of two stop bits checked
// - framing/parity error copies byte, no rx_full
// - parity mismatch sets parity error flag
// - tx_end means last bit sent with transmit data register empty
// - tx_end set when tx off or last bit sent while empty
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module ssf_status
   import ssf_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic standby,
   input wire logic module_stop,
   input wire ssf_bus_t bus,
   output logic [7:0] rd_data,
   input wire logic tx_load,
   input wire logic tx_last_bit,
   input wire ssf_rx_t rx,
   input wire logic xfer_tx_write,
   input wire logic [7:0] xfer_tx_data,
   input wire logic xfer_rx_read,
   input wire logic chain_disable_select,
   input wire logic xfer_count_nonzero,
   output logic [7:0] tx_byte,
   output logic tx_mpb,
   output logic tx_en,
   output logic rx_en,
   output logic [7:0] mode,
   output logic tx_halt,
   output logic rx_halt,
   output logic tx_empty_req,
   output logic rx_full_req
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [4:0] fl_q;
   logic [4:0] rd1_q;
   logic tx_end_q;
   logic mpb_q;
   logic tx_multiproc_bit_q;
   logic [7:0] tdr_q;
   logic [7:0] rdr_q;
   logic [7:0] ctl_q;
   logic [7:0] mode_q;
   logic [7:0] rdata_q;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   wire logic st_wr;
   wire logic st_rd;
   wire logic tdr_wr;
   wire logic ctl_wr;
   wire logic mode_wr;
   wire logic [7:0] status;
   wire logic [7:0] rd_mux;
   wire logic flag_rst;

   assign st_wr = bus.we && bus.addr == SSF_OFS_STATUS;
   assign st_rd = bus.re && bus.addr == SSF_OFS_STATUS;
   assign tdr_wr = bus.we && bus.addr == SSF_OFS_TX_DATA;
   assign ctl_wr = bus.we && bus.addr == SSF_OFS_CONTROL;
   assign mode_wr = bus.we && bus.addr == SSF_OFS_MODE;
   assign flag_rst = sys_rst || standby || module_stop;
   assign status = {fl_q, tx_end_q, mpb_q, tx_multiproc_bit_q};
   assign rd_mux = (bus.addr == SSF_OFS_STATUS) ? status :
                   (bus.addr == SSF_OFS_TX_DATA) ? tdr_q :
                   (bus.addr == SSF_OFS_RX_DATA) ? rdr_q :
                   (bus.addr == SSF_OFS_CONTROL) ? ctl_q :
                   (bus.addr == SSF_OFS_MODE) ? mode_q : 8'h00;

   // ----------------------------------------------------------------
   // mode and enables
   // ----------------------------------------------------------------
   wire logic sync_mode;
   wire logic err_halt;

   assign tx_en = ctl_q[SSF_CTL_TXEN];
   assign rx_en = ctl_q[SSF_CTL_RXEN];
   assign mode = mode_q;
   assign sync_mode = mode_q[SSF_MODE_SYNC];
   assign err_halt = fl_q[SSF_FL_OVERRUN_ERROR] || fl_q[SSF_FL_FER] || fl_q[SSF_FL_PER];
   assign rx_halt = err_halt;
   assign tx_halt = err_halt && sync_mode;

   // ----------------------------------------------------------------
   // receive events
   // ----------------------------------------------------------------
   wire logic fer_hit;
   wire logic per_hit;
   wire logic rx_acc;
   wire logic rx_over;
   wire logic rx_clean;
   wire logic rdr_load;

   ssf_rx_check u_check (
      .rx(rx),
      .sync_mode(sync_mode),
      .par_en(mode_q[SSF_MODE_PAR_EN]),
      .par_odd(mode_q[SSF_MODE_ODD]),
      .two_stop(mode_q[SSF_MODE_TWO_STOP]),
      .fer_hit(fer_hit),
      .per_hit(per_hit)
   );

   // receiver ignored while disabled or halted by an error
   assign rx_acc = rx.done && rx_en && !err_halt;
   assign rx_over = rx_acc && fl_q[SSF_FL_RX_BUFFER_FULL];
   assign rx_clean = rx_acc && !rx_over && !fer_hit && !per_hit;
   assign rdr_load = rx_acc && !rx_over;

   // ----------------------------------------------------------------
   // transfer controller gating
   // ----------------------------------------------------------------
   wire logic xfer_ok;
   wire logic xfer_tx_clr;
   wire logic xfer_rx_clr;

   assign xfer_ok = !chain_disable_select && xfer_count_nonzero;
   assign xfer_tx_clr = xfer_tx_write && xfer_ok;
   assign xfer_rx_clr = xfer_rx_read && xfer_ok;

   // ----------------------------------------------------------------
   // flag next values
   // ----------------------------------------------------------------
   wire logic [4:0] fl_set;
   wire logic [4:0] cpu_clr;
   wire logic [4:0] fl_clr;
   wire logic [4:0] fl_d;
   wire logic [4:0] rd1_d;
   wire logic [4:0] rd1_seen;
   wire logic tx_end_set;
   wire logic tx_end_d;

   assign fl_set = {!tx_en || tx_load,
                    rx_clean,
                    rx_over,
                    rx_acc && fer_hit,
                    rx_acc && per_hit};
   // a one in the write data leaves the flag alone
   assign cpu_clr = {5{st_wr}} & ~bus.wdata[7:3] & rd1_q;
   assign fl_clr = cpu_clr | {xfer_tx_clr, xfer_rx_clr, 3'b000};
   // set wins over any clear in the same cycle
   assign fl_d = fl_set | (fl_q & ~fl_clr);
   assign rd1_seen = st_rd ? (fl_q & ~fl_set) : 5'b00000;
   assign rd1_d = (rd1_q & ~fl_set & ~fl_clr) | rd1_seen;
   assign tx_end_set = !tx_en || (tx_last_bit && fl_q[SSF_FL_TX_BUFFER_EMPTY]);
   assign tx_end_d = tx_end_set || (tx_end_q && !fl_clr[SSF_FL_TX_BUFFER_EMPTY]);

   // ----------------------------------------------------------------
   // status register
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (flag_rst) begin
         fl_q <= SSF_FL_RST;
         rd1_q <= 5'b00000;
         tx_end_q <= SSF_TX_END_RST;
         mpb_q <= SSF_STATUS_RST[SSF_BIT_MPB];
         tx_multiproc_bit_q <= SSF_STATUS_RST[SSF_BIT_TX_MULTIPROC_BIT];
      end else begin
         fl_q <= fl_d;
         rd1_q <= rd1_d;
         tx_end_q <= tx_end_d;
         if (rx_acc) begin
            mpb_q <= rx.rx_multiproc_bit;
         end
         if (st_wr) begin
            tx_multiproc_bit_q <= bus.wdata[SSF_BIT_TX_MULTIPROC_BIT];
         end
      end
   end

   // ----------------------------------------------------------------
   // data, control and read-back registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tdr_q <= SSF_DATA_RST;
         rdr_q <= 8'h00;
         ctl_q <= SSF_CTL_RST;
         mode_q <= SSF_MODE_RST;
         rdata_q <= 8'h00;
      end else begin
         if (xfer_tx_write) begin
            tdr_q <= xfer_tx_data;
         end else if (tdr_wr) begin
            tdr_q <= bus.wdata;
         end
         if (rdr_load) begin
            rdr_q <= rx.data;
         end
         if (ctl_wr) begin
            ctl_q <= bus.wdata;
         end
         if (mode_wr) begin
            mode_q <= bus.wdata;
         end
         rdata_q <= bus.re ? rd_mux : 8'h00;
      end
   end

   assign rd_data = rdata_q;
   assign tx_byte = tdr_q;
   assign tx_mpb = tx_multiproc_bit_q;
   assign tx_empty_req = fl_q[SSF_FL_TX_BUFFER_EMPTY];
   assign rx_full_req = fl_q[SSF_FL_RX_BUFFER_FULL];

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_rd_rx_buffer_full_one;
      st_rd && fl_q[SSF_FL_RX_BUFFER_FULL] && !rx_clean && !xfer_rx_clr;
   endsequence

   sequence s_wr_rx_buffer_full_zero;
      st_wr && !bus.wdata[SSF_BIT_RX_BUFFER_FULL] && !rx_clean && !standby && !module_stop;
   endsequence

   property p_low_power_reset;
      (standby || module_stop) |=> status == SSF_STATUS_RST;
   endproperty
   a_low_power_reset: assert property (p_low_power_reset) else $error("status not 84h after low power entry");

   property p_one_write_keeps;
      st_wr && bus.wdata[SSF_BIT_RX_BUFFER_FULL] && fl_q[SSF_FL_RX_BUFFER_FULL] && !xfer_rx_clr && !flag_rst |=> fl_q[SSF_FL_RX_BUFFER_FULL];
   endproperty
   a_one_write_keeps: assert property (p_one_write_keeps) else $error("one write changed a flag");

   property p_clear_needs_read;
      st_wr && !bus.wdata[SSF_BIT_OVERRUN_ERROR] && fl_q[SSF_FL_OVERRUN_ERROR] && !rd1_q[SSF_FL_OVERRUN_ERROR] && !flag_rst
         |=> fl_q[SSF_FL_OVERRUN_ERROR];
   endproperty
   a_clear_needs_read: assert property (p_clear_needs_read) else $error("flag cleared without prior read");

   property p_read_then_clear;
      s_rd_rx_buffer_full_one ##1 s_wr_rx_buffer_full_zero |=> !fl_q[SSF_FL_RX_BUFFER_FULL];
   endproperty
   a_read_then_clear: assert property (p_read_then_clear) else $error("read one, zero write kept flag");

   property p_read_only_bits;
      st_wr && !rx_acc && !flag_rst && !tx_end_set && !fl_clr[SSF_FL_TX_BUFFER_EMPTY] |=> $stable(mpb_q) && $stable(tx_end_q);
   endproperty
   a_read_only_bits: assert property (p_read_only_bits) else $error("read-only bit changed by write");

   property p_tx_off_empty;
      !tx_en && !flag_rst |=> fl_q[SSF_FL_TX_BUFFER_EMPTY] && tx_end_q;
   endproperty
   a_tx_off_empty: assert property (p_tx_off_empty) else $error("tx off but empty or end flag low");

   property p_xfer_clear_tx;
      xfer_tx_write && xfer_ok && tx_en && !tx_load && !flag_rst
         |=> !fl_q[SSF_FL_TX_BUFFER_EMPTY] && tx_byte == $past(xfer_tx_data);
   endproperty
   a_xfer_clear_tx: assert property (p_xfer_clear_tx) else $error("controller write left tx empty set");

   property p_xfer_gated;
      xfer_rx_read && chain_disable_select && fl_q[SSF_FL_RX_BUFFER_FULL] && !cpu_clr[SSF_FL_RX_BUFFER_FULL] && !flag_rst
         |=> fl_q[SSF_FL_RX_BUFFER_FULL];
   endproperty
   a_xfer_gated: assert property (p_xfer_gated) else $error("controller cleared despite chain disable");

   property p_clean_rx;
      rx_clean && !flag_rst |=> fl_q[SSF_FL_RX_BUFFER_FULL] && rdr_q == $past(rx.data);
   endproperty
   a_clean_rx: assert property (p_clean_rx) else $error("clean reception not stored");

   property p_rx_off_holds;
      rx.done && !rx_en |=> $stable(rdr_q);
   endproperty
   a_rx_off_holds: assert property (p_rx_off_holds) else $error("disabled receiver changed data");

   property p_overrun;
      rx_over && !flag_rst |=> fl_q[SSF_FL_OVERRUN_ERROR] && $stable(rdr_q) && fl_q[SSF_FL_RX_BUFFER_FULL] == !$past(xfer_rx_clr);
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged or data overwritten");

   property p_halt;
      err_halt |-> rx_halt && (tx_halt == sync_mode) ##1 !($past(rx.done) && $changed(rdr_q));
   endproperty
   a_halt: assert property (p_halt) else $error("error flag did not halt");

   property p_framing;
      rx_acc && !sync_mode && !rx.stop[0] && !rx_over && !flag_rst
         |=> fl_q[SSF_FL_FER] && rdr_q == $past(rx.data) && (fl_q[SSF_FL_RX_BUFFER_FULL] == 1'b0);
   endproperty
   a_framing: assert property (p_framing) else $error("framing error mishandled");

   property p_second_stop;
      rx_acc && !sync_mode && rx.stop == 2'b01 && !err_halt && !flag_rst |=> !fl_q[SSF_FL_FER];
   endproperty
   a_second_stop: assert property (p_second_stop) else $error("second stop bit was checked");

   property p_tx_end_set;
      tx_last_bit && fl_q[SSF_FL_TX_BUFFER_EMPTY] && !flag_rst |=> tx_end_q;
   endproperty
   a_tx_end_set: assert property (p_tx_end_set) else $error("end flag not set on last bit");

   property p_xfer_clear_rx;
      xfer_rx_read && xfer_ok && !rx_clean && !flag_rst |=> !fl_q[SSF_FL_RX_BUFFER_FULL];
   endproperty
   a_xfer_clear_rx: assert property (p_xfer_clear_rx) else $error("controller read left rx full set");

   property p_err_copies;
      rx_acc && !rx_over && (fer_hit || per_hit) && !flag_rst
         |=> rdr_q == $past(rx.data) && !fl_q[SSF_FL_RX_BUFFER_FULL];
   endproperty
   a_err_copies: assert property (p_err_copies) else $error("errored byte not copied or rx full set");

   property p_rx_off_keeps_err;
      !rx_en && !st_wr && !flag_rst |=> $stable(fl_q[SSF_FL_OVERRUN_ERROR:SSF_FL_PER]);
   endproperty
   a_rx_off_keeps_err: assert property (p_rx_off_keeps_err) else $error("error flags changed with rx off");

   property p_parity;
      rx_acc && !sync_mode && mode_q[SSF_MODE_PAR_EN] && ((^{rx.data, rx.parity}) != mode_q[SSF_MODE_ODD])
         && !flag_rst |=> fl_q[SSF_FL_PER];
   endproperty
   a_parity: assert property (p_parity) else $error("parity mismatch not flagged");

   property p_set_drops_record;
      fl_set[SSF_FL_TX_BUFFER_EMPTY] && !st_rd && !flag_rst |=> !rd1_q[SSF_FL_TX_BUFFER_EMPTY];
   endproperty
   a_set_drops_record: assert property (p_set_drops_record) else $error("stale read-one record");

endmodule : ssf_status
